// [bief_core.sv]
// Purpose: Configuration and status logic of one bridge input in extended filter mode
// Assumes: Single 50 MHz clock, synchronous active low reset, front end signals synchronous
// Notes: Plain register port, read data one cycle after read strobe
// Operation
// - Low four config bits select IIR level
// - Config bits 4..6 decode measurement range
// - Rate mode zero coded, one high resolution
// - Rate source follows selected rate mode
// - Coded rates fourteen, fifteen force invalid value in coded mode
// - Fine rate zero disables FIR filter in high resolution mode
// - Supply fault forces invalid, flushes filters
// - Status bits flag invalid value, open circuit
// - Status bit three: module supply error
// - Status bit four: gauge supply error
// - Status bit five until FIR ready
// - Unsigned 32-bit microsecond conversion timestamp
`timescale 1ns/1ps
`default_nettype none
`include "bief_map.svh"

module bief_core #(
    parameter int unsigned TICKS_PER_US = `BIEF_TICKS_PER_US,
    parameter logic [15:0] DEV_ID = 16'h5a5a // Arbitrary value
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [`BIEF_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire bief_pkg::bief_front_t front_i,
    output bief_pkg::bief_ctrl_t ctrl_o,
    output logic irq_o
);

    typedef struct packed {
        logic [7:0] filt_cfg;
        logic [15:0] rate_mode;
        logic [7:0] coded_rate;
        logic [15:0] fine_rate;
        logic [7:0] status;
        logic [31:0] tstamp;
        logic [31:0] us_cnt;
        logic [7:0] tick;
        logic [`BIEF_IRQ_W-1:0] irq_stat;
        logic [`BIEF_IRQ_W-1:0] irq_mask;
        logic supply_bad;
        bief_pkg::bief_fir_t fir;
        logic [31:0] rdata;
        bief_pkg::bief_ctrl_t ctrl;
        logic irq;
    } bief_state_t;

    bief_state_t st_ff;
    bief_state_t nxt_st;

    localparam logic [7:0] TICK_LAST = 8'(TICKS_PER_US - 1);

    logic supply_bad;
    logic hires;
    logic fir_enabled;
    logic [`BIEF_IRQ_W-1:0] irq_evt;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        supply_bad = front_i.mod_pwr_err | front_i.gauge_pwr_err;
        hires = (st_ff.rate_mode == `BIEF_MODE_HIRES);
        fir_enabled = hires ? (st_ff.fine_rate != `BIEF_FIR_DISABLED) : 1'b1;
        irq_evt = '0;

        // Free running microsecond time base
        if (st_ff.tick == TICK_LAST) begin
            nxt_st.tick = '0;
            nxt_st.us_cnt = st_ff.us_cnt + 32'h1;
        end else begin
            nxt_st.tick = st_ff.tick + 8'h1;
        end
        if (front_i.conv_done) begin
            nxt_st.tstamp = st_ff.us_cnt;
        end

        // FIR readiness tracking
        case (st_ff.fir)
            bief_pkg::BIEF_FIR_OFF: begin
                if (fir_enabled && !supply_bad) begin
                    nxt_st.fir = bief_pkg::BIEF_FIR_SETTLE;
                end
            end
            bief_pkg::BIEF_FIR_SETTLE: begin
                if (!fir_enabled || supply_bad) begin
                    nxt_st.fir = bief_pkg::BIEF_FIR_OFF;
                end else if (front_i.fir_settled) begin
                    nxt_st.fir = bief_pkg::BIEF_FIR_RUN;
                end
            end
            bief_pkg::BIEF_FIR_RUN: begin
                if (!fir_enabled || supply_bad) begin
                    nxt_st.fir = bief_pkg::BIEF_FIR_OFF;
                end
            end
            default: nxt_st.fir = bief_pkg::BIEF_FIR_OFF;
        endcase

        // Status register
        nxt_st.supply_bad = supply_bad;
        nxt_st.status = '0;
        nxt_st.status[`BIEF_ST_INVALID] = front_i.adc_invalid | supply_bad;
        nxt_st.status[`BIEF_ST_OPEN] = front_i.open_circuit;
        nxt_st.status[`BIEF_ST_MOD_PWR] = front_i.mod_pwr_err;
        nxt_st.status[`BIEF_ST_GAUGE_PWR] = front_i.gauge_pwr_err;
        nxt_st.status[`BIEF_ST_NOT_READY] = (nxt_st.fir != bief_pkg::BIEF_FIR_RUN);

        // Control outputs to the front end
        nxt_st.ctrl.iir_level = st_ff.filt_cfg[3:0];
        nxt_st.ctrl.iir_on = (st_ff.filt_cfg[3:0] != 4'h0);
        nxt_st.ctrl.range_code = st_ff.filt_cfg[6:4];
        nxt_st.ctrl.range_extended = st_ff.filt_cfg[6];
        nxt_st.ctrl.fir_hires = hires;
        nxt_st.ctrl.coded_rate = st_ff.coded_rate[3:0];
        nxt_st.ctrl.fine_rate = st_ff.fine_rate;
        nxt_st.ctrl.fir_on = fir_enabled;
        nxt_st.ctrl.force_invalid = (st_ff.filt_cfg[3:0] > `BIEF_IIR_MAX)
            | (!hires && st_ff.coded_rate[3:0] > `BIEF_RATE_MAX)
            | supply_bad;
        nxt_st.ctrl.flush = supply_bad & ~st_ff.supply_bad;

        // Interrupt events
        irq_evt[`BIEF_IRQ_CONV] = front_i.conv_done;
        irq_evt[`BIEF_IRQ_OPEN] = front_i.open_circuit & ~st_ff.status[`BIEF_ST_OPEN];
        irq_evt[`BIEF_IRQ_SUPPLY] = supply_bad & ~st_ff.supply_bad;
        irq_evt[`BIEF_IRQ_READY] = (nxt_st.fir == bief_pkg::BIEF_FIR_RUN)
            && (st_ff.fir != bief_pkg::BIEF_FIR_RUN);

        // Register writes; reserved bits ignored
        if (reg_wr_i) begin
            case (reg_addr_i)
                `BIEF_OFS_FILT_CFG: nxt_st.filt_cfg = {1'b0, reg_wdata_i[6:0]};
                `BIEF_OFS_RATE_MODE: nxt_st.rate_mode = reg_wdata_i[15:0];
                `BIEF_OFS_CODED_RATE: nxt_st.coded_rate = {4'h0, reg_wdata_i[3:0]};
                `BIEF_OFS_FINE_RATE: nxt_st.fine_rate = reg_wdata_i[15:0];
                `BIEF_OFS_IRQ_STAT: nxt_st.irq_stat = st_ff.irq_stat & ~reg_wdata_i[`BIEF_IRQ_W-1:0];
                `BIEF_OFS_IRQ_MASK: nxt_st.irq_mask = reg_wdata_i[`BIEF_IRQ_W-1:0];
                default: ;
            endcase
        end
        // Set wins over clear
        nxt_st.irq_stat = nxt_st.irq_stat | irq_evt;
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

        // Register reads
        nxt_st.rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `BIEF_OFS_FILT_CFG: nxt_st.rdata = {24'h0, st_ff.filt_cfg};
                `BIEF_OFS_RATE_MODE: nxt_st.rdata = {16'h0, st_ff.rate_mode};
                `BIEF_OFS_CODED_RATE: nxt_st.rdata = {24'h0, st_ff.coded_rate};
                `BIEF_OFS_FINE_RATE: nxt_st.rdata = {16'h0, st_ff.fine_rate};
                `BIEF_OFS_STATUS: nxt_st.rdata = {24'h0, st_ff.status};
                `BIEF_OFS_TSTAMP: nxt_st.rdata = st_ff.tstamp;
                `BIEF_OFS_IRQ_STAT: nxt_st.rdata = {{(32-`BIEF_IRQ_W){1'b0}}, st_ff.irq_stat};
                `BIEF_OFS_IRQ_MASK: nxt_st.rdata = {{(32-`BIEF_IRQ_W){1'b0}}, st_ff.irq_mask};
                `BIEF_OFS_DEV_ID: nxt_st.rdata = {16'h0, DEV_ID};
                default: nxt_st.rdata = '0;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
            st_ff.fir <= bief_pkg::BIEF_FIR_OFF;
            st_ff.status <= `BIEF_STATUS_RST;
        end else if (clk_en_i) begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_o = st_ff.rdata;
    assign ctrl_o = st_ff.ctrl;
    assign irq_o = st_ff.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_fault_seen;
        clk_en_i && (front_i.mod_pwr_err || front_i.gauge_pwr_err);
    endsequence

    property p_iir_invalid;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && st_ff.filt_cfg[3:0] > `BIEF_IIR_MAX) |=> ctrl_o.force_invalid;
    endproperty
    a_iir_invalid: assert property (p_iir_invalid) else $error("IIR code over 8 not invalid");

    property p_range;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (ctrl_o.range_code == $past(st_ff.filt_cfg[6:4]));
    endproperty
    a_range: assert property (p_range) else $error("Range code not following config");

    property p_rate_invalid;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !hires && st_ff.coded_rate[3:0] > `BIEF_RATE_MAX) |=> ctrl_o.force_invalid;
    endproperty
    a_rate_invalid: assert property (p_rate_invalid) else $error("Coded rate over 13 not invalid");

    property p_fine_off;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && hires && st_ff.fine_rate == `BIEF_FIR_DISABLED) |=> !ctrl_o.fir_on;
    endproperty
    a_fine_off: assert property (p_fine_off) else $error("FIR on with fine rate zero");

    property p_fault;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_fault_seen |=> ctrl_o.force_invalid && st_ff.status[`BIEF_ST_INVALID];
    endproperty
    a_fault: assert property (p_fault) else $error("Supply fault without invalid value");

    property p_mod_pwr;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (st_ff.status[`BIEF_ST_MOD_PWR] == $past(front_i.mod_pwr_err));
    endproperty
    a_mod_pwr: assert property (p_mod_pwr) else $error("Module supply bit wrong");

    property p_gauge_pwr;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (st_ff.status[`BIEF_ST_GAUGE_PWR] == $past(front_i.gauge_pwr_err));
    endproperty
    a_gauge_pwr: assert property (p_gauge_pwr) else $error("Gauge supply bit wrong");

    property p_not_ready;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_fault_seen |=> st_ff.status[`BIEF_ST_NOT_READY];
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("FIR ready during supply fault");

    property p_tstamp;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && front_i.conv_done) |=> (st_ff.tstamp == $past(st_ff.us_cnt));
    endproperty
    a_tstamp: assert property (p_tstamp) else $error("Timestamp not captured");

    property p_wrap;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && st_ff.tick == TICK_LAST) |=> (st_ff.us_cnt == $past(st_ff.us_cnt) + 32'h1);
    endproperty
    a_wrap: assert property (p_wrap) else $error("Microsecond counter step wrong");

    sequence s_fault_rise;
        clk_en_i && supply_bad && !st_ff.supply_bad;
    endsequence

    property p_open;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (st_ff.status[`BIEF_ST_OPEN] == $past(front_i.open_circuit));
    endproperty
    a_open: assert property (p_open) else $error("Open circuit bit wrong");

    property p_invalid_bit;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (st_ff.status[`BIEF_ST_INVALID] == $past(front_i.adc_invalid || supply_bad));
    endproperty
    a_invalid_bit: assert property (p_invalid_bit) else $error("Invalid value bit wrong");

    property p_hires;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (ctrl_o.fir_hires == ($past(st_ff.rate_mode) == `BIEF_MODE_HIRES));
    endproperty
    a_hires: assert property (p_hires) else $error("Rate mode decode wrong");

    property p_coded_pass;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (ctrl_o.coded_rate == $past(st_ff.coded_rate[3:0]));
    endproperty
    a_coded_pass: assert property (p_coded_pass) else $error("Coded rate not passed on");

    property p_fine_pass;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (ctrl_o.fine_rate == $past(st_ff.fine_rate));
    endproperty
    a_fine_pass: assert property (p_fine_pass) else $error("Fine rate not passed on");

    property p_reserved;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !st_ff.filt_cfg[7] && (st_ff.coded_rate[7:4] == 4'h0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bits stored");

    property p_iir_level;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (ctrl_o.iir_level == $past(st_ff.filt_cfg[3:0]));
    endproperty
    a_iir_level: assert property (p_iir_level) else $error("IIR level not passed on");

    property p_range_ext;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (ctrl_o.range_extended == $past(st_ff.filt_cfg[6]));
    endproperty
    a_range_ext: assert property (p_range_ext) else $error("Extended range flag wrong");

    property p_ready;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && st_ff.fir == bief_pkg::BIEF_FIR_RUN && fir_enabled && !supply_bad)
            |=> !st_ff.status[`BIEF_ST_NOT_READY];
    endproperty
    a_ready: assert property (p_ready) else $error("Ready FIR flagged not ready");

    property p_flush;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_fault_rise |=> ctrl_o.flush;
    endproperty
    a_flush: assert property (p_flush) else $error("No flush on supply fault");

    property p_freeze;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !clk_en_i |=> $stable(st_ff);
    endproperty
    a_freeze: assert property (p_freeze) else $error("State moved while disabled");

    property p_rdata_idle;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !reg_rd_i) |=> (reg_rdata_o == 32'h0);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("Read data without read");

    property p_irq_level;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (irq_o == |(st_ff.irq_stat & st_ff.irq_mask));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong");

endmodule // bief_core
`default_nettype wire

// [bief_front_model.sv]
// Purpose: Front end model driving the bridge input status lines
// Assumes: Bench changes levels right after rising edges
// Notes: Conversion strobe is one cycle wide
`timescale 1ns/1ps
`default_nettype none
module bief_front_model (
    input wire logic [4:0] lvl_i,
    input wire logic conv_i,
    output bief_pkg::bief_front_t front_o
);
    assign front_o.conv_done = conv_i;
    assign front_o.open_circuit = lvl_i[4];
    assign front_o.mod_pwr_err = lvl_i[3];
    assign front_o.gauge_pwr_err = lvl_i[2];
    // Supply fault spoils the raw value
    assign front_o.adc_invalid = |lvl_i[3:1];
    assign front_o.fir_settled = lvl_i[0];
endmodule // bief_front_model
`default_nettype wire

// [bief_map.svh]
// Purpose: Register offsets, fields and timing counts for the bridge input extended filter
// Assumes: Word-indexed plain register port
// Notes: Included by the package and the design
`ifndef BIEF_MAP_SVH
`define BIEF_MAP_SVH

`define BIEF_ADDR_W 4
`define BIEF_OFS_FILT_CFG 4'h0
`define BIEF_OFS_RATE_MODE 4'h1
`define BIEF_OFS_CODED_RATE 4'h2
`define BIEF_OFS_FINE_RATE 4'h3
`define BIEF_OFS_STATUS 4'h4
`define BIEF_OFS_TSTAMP 4'h5
`define BIEF_OFS_IRQ_STAT 4'h6
`define BIEF_OFS_IRQ_MASK 4'h7
`define BIEF_OFS_DEV_ID 4'h8

`define BIEF_IIR_MAX 4'h8
`define BIEF_RATE_MAX 4'hd
`define BIEF_MODE_HIRES 16'h0001
`define BIEF_FIR_DISABLED 16'h0000
`define BIEF_STATUS_RST 8'h20

`define BIEF_ST_INVALID 0
`define BIEF_ST_OPEN 1
`define BIEF_ST_MOD_PWR 3
`define BIEF_ST_GAUGE_PWR 4
`define BIEF_ST_NOT_READY 5

`define BIEF_IRQ_W 4
`define BIEF_IRQ_CONV 0
`define BIEF_IRQ_OPEN 1
`define BIEF_IRQ_SUPPLY 2
`define BIEF_IRQ_READY 3

`define BIEF_CLK_MHZ 50
`define BIEF_US_NS 1000
`define BIEF_CLK_NS 20
`define BIEF_TICKS_PER_US (`BIEF_US_NS / `BIEF_CLK_NS)

`endif

// [bief_pkg.sv]
// Purpose: Types for the bridge input extended filter
// Assumes: bief_map.svh holds the numbers
// Notes: Nothing is imported elsewhere
`include "bief_map.svh"
package bief_pkg;
    typedef enum logic [1:0] {
        BIEF_FIR_RUN = 2'b00,
        BIEF_FIR_OFF = 2'b01,
        BIEF_FIR_SETTLE = 2'b11
    } bief_fir_t;

    typedef struct packed {
        logic conv_done;
        logic open_circuit;
        logic mod_pwr_err;
        logic gauge_pwr_err;
        logic adc_invalid;
        logic fir_settled;
    } bief_front_t;

    typedef struct packed {
        logic [3:0] iir_level;
        logic iir_on;
        logic [2:0] range_code;
        logic range_extended;
        logic fir_on;
        logic fir_hires;
        logic [3:0] coded_rate;
        logic [15:0] fine_rate;
        logic force_invalid;
        logic flush;
    } bief_ctrl_t;
endpackage

// [test_bridge_input_extended_filter.sv]
// Purpose: Register level test of the bridge input extended filter
// Assumes: Front end model beside the design
// Notes: Timestamp tick shortened to two cycles
`timescale 1ns/1ps
`default_nettype none
`include "bief_map.svh"
module test_bridge_input_extended_filter;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [`BIEF_ADDR_W-1:0] reg_addr_i = '0;
    logic [31:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [4:0] lvl = '0;
    logic conv = 1'b0;
    bief_pkg::bief_front_t front;
    bief_pkg::bief_ctrl_t ctrl_o;
    logic irq_o;
    logic [31:0] rd;
    logic [31:0] t1;
    int fail_count = 0;
    int comparisons = 0;
    always #10 core_clk_i = ~core_clk_i;
    bief_front_model fm_u (.lvl_i(lvl), .conv_i(conv), .front_o(front));
    // Identity value is arbitrary
    bief_core #(.TICKS_PER_US(2), .DEV_ID(16'h1234)) dut_u (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .front_i(front),
        .ctrl_o(ctrl_o), .irq_o(irq_o));
    // ****************
    // Bus, stimulus and check tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd = reg_rdata_o;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic set_lvl(input logic [4:0] v);
        @(posedge core_clk_i);
        lvl <= v;
    endtask
    task automatic pulse;
        @(posedge core_clk_i);
        conv <= 1'b1;
        @(posedge core_clk_i);
        conv <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ****************
    // Tests
    // ****************
    initial begin
        #400000;
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rdr(`BIEF_OFS_STATUS);
        chk("status", rd, 32'h20);
        rdr(`BIEF_OFS_RATE_MODE);
        chk("mode", rd, 32'h0);
        rdr(`BIEF_OFS_DEV_ID);
        chk("id", rd, 32'h1234);
        rdr(4'hf);
        chk("unmapped", rd, 32'h0);
        wr(`BIEF_OFS_STATUS, 32'hff);
        rdr(`BIEF_OFS_STATUS);
        chk("status ro", rd, 32'h20);
        for (int i = 0; i < 16; i++) begin
            wr(`BIEF_OFS_FILT_CFG, {25'h0, i[2:0], i[3:0]});
            tick(1);
            chk("range", ctrl_o.range_code, i[2:0]);
            chk("ext", ctrl_o.range_extended, i[2]);
            chk("iir inv", ctrl_o.force_invalid, i > 8);
            if (i <= 8) chk("iir", {ctrl_o.iir_level, ctrl_o.iir_on}, {i[3:0], i != 0});
        end
        wr(`BIEF_OFS_FILT_CFG, 32'h0);
        for (int c = 0; c < 16; c++) begin
            wr(`BIEF_OFS_CODED_RATE, c);
            tick(1);
            chk("coded", {ctrl_o.fir_hires, ctrl_o.fir_on, ctrl_o.coded_rate}, {2'b01, c[3:0]});
            chk("rate inv", ctrl_o.force_invalid, c > 13);
        end
        wr(`BIEF_OFS_CODED_RATE, 32'h0);
        wr(`BIEF_OFS_RATE_MODE, 32'h1);
        tick(1);
        chk("fine off", {ctrl_o.fir_hires, ctrl_o.fir_on}, 2'b10);
        wr(`BIEF_OFS_FINE_RATE, 32'hffff);
        tick(1);
        chk("fine", {ctrl_o.fir_on, ctrl_o.fine_rate}, 17'h1ffff);
        wr(`BIEF_OFS_RATE_MODE, 32'h0);
        tick(1);
        chk("mode back", ctrl_o.fir_hires, 1'b0);
        wr(`BIEF_OFS_IRQ_MASK, 32'hf);
        wr(`BIEF_OFS_IRQ_STAT, 32'hf);
        tick(1);
        chk("irq idle", irq_o, 1'b0);
        set_lvl(5'b01000);
        tick(1);
        chk("flush", {ctrl_o.flush, ctrl_o.force_invalid}, 2'b11);
        tick(1);
        chk("flush end", {ctrl_o.flush, irq_o}, 2'b01);
        rdr(`BIEF_OFS_STATUS);
        chk("mod err", rd, 32'h29);
        set_lvl(5'b00100);
        tick(1);
        rdr(`BIEF_OFS_STATUS);
        chk("gauge err", rd, 32'h31);
        rdr(`BIEF_OFS_IRQ_STAT);
        chk("irq stat", rd, 32'h4);
        wr(`BIEF_OFS_IRQ_STAT, 32'h4);
        wr(`BIEF_OFS_IRQ_MASK, 32'h0);
        set_lvl(5'b10000);
        tick(2);
        chk("irq masked", irq_o, 1'b0);
        rdr(`BIEF_OFS_STATUS);
        chk("open", rd, 32'h22);
        set_lvl(5'b00001);
        tick(10);
        rdr(`BIEF_OFS_STATUS);
        chk("ready", rd, 32'h00);
        rdr(`BIEF_OFS_IRQ_STAT);
        chk("irq sticky", rd, 32'ha);
        pulse();
        rdr(`BIEF_OFS_TSTAMP);
        t1 = rd;
        repeat (16) @(posedge core_clk_i);
        pulse();
        rdr(`BIEF_OFS_TSTAMP);
        chk("tstamp", rd - t1, 32'ha);
        wr(`BIEF_OFS_FILT_CFG, 32'h15);
        @(posedge core_clk_i);
        clk_en_i <= 1'b0;
        wr(`BIEF_OFS_FILT_CFG, 32'h3);
        @(posedge core_clk_i);
        clk_en_i <= 1'b1;
        rdr(`BIEF_OFS_FILT_CFG);
        chk("freeze", rd, 32'h15);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rdr(`BIEF_OFS_STATUS);
        chk("reset status", rd, 32'h20);
        rdr(`BIEF_OFS_FILT_CFG);
        chk("reset cfg", rd, 32'h0);
        give_verdict();
    end
endmodule // test_bridge_input_extended_filter
`default_nettype wire
